/* File: rtl/crs_status_cfg.svh */
// constants of the command response and channel status registers
`ifndef CRS_STATUS_CFG_SVH
`define CRS_STATUS_CFG_SVH
`define CRS_ADDR_RESPONSE     8'h11
`define CRS_ADDR_IRQ_FLAGS    8'h12
`define CRS_BIT_RUNNING       7
`define CRS_BIT_SUSPENDED     6
`define CRS_BIT_IDLE          5
`define CRS_BIT_ERROR         4
`define CRS_TALLY_RESET       4'hF
`define CRS_TALLY_ZERO        4'h0
`define CRS_ERR_INVALID_CMD   4'h0
`define CRS_ERR_PARAM_RANGE   4'h1
`define CRS_ERR_SATURATION    4'h2
`define CRS_ERR_BUF_OVERFLOW  4'h3
`define CRS_RESULT_AREA_BYTES 6'h1A
`define CRS_CHANNELS          6
`endif

/* File: rtl/crs_status_pkg.sv */
// types of the command response and channel status registers
package crs_status_pkg;
  typedef enum logic [1:0] {
    CRS_SEQ_RUNNING   = 2'b00,
    CRS_SEQ_SUSPENDED = 2'b01,
    CRS_SEQ_IDLE      = 2'b10
  } crs_seq_type;
  typedef enum logic [2:0] {
    CRS_EV_NONE      = 3'b000,
    CRS_EV_INVALID   = 3'b001,
    CRS_EV_PARAM     = 3'b010,
    CRS_EV_SATURATE  = 3'b011,
    CRS_EV_OVERFLOW  = 3'b100
  } crs_err_type;
endpackage : crs_status_pkg

/* File: rtl/crs_status.sv */
// command response byte and per-channel done flags of the light sensor
`timescale 1ns/1ps
`include "crs_status_cfg.svh"

// How it works
// RULE1 - bits 7:5 of the response show sequencer running, suspended or idle.
// RULE2 - after reset show running; show idle once initialization is done.
// RULE3 - error flag clears on power-up, soft restart and tally clear command.
// RULE4 - error flag sets whenever a command is rejected, e.g. table overrun.
// RULE5 - with error set, low field holds code 0 to 3 for the cause.
// RULE6 - with error clear, tally increments on each accepted executed command.
// RULE7 - tally clear command sets the tally to zero.
// RULE8 - power-up and soft restart load the tally with all ones.
// RULE9 - burst output longer than the 26-byte result area raises overflow error.
// RULE10 - six done flags, one per channel, cleared by reading, reset to zero.
// RULE11 - done flag bits 7:6 read zero and ignore writes.
// RULE12 - tally clear command touches nothing else; the code also clears the error flag.
// RULE13 - a result is valid once its flag is set, until next measurement.
// RULE14 - host reads the response after each command to confirm the outcome.
module crs_status (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      softRestart,
  input  wire logic                      initDone,
  input  wire crs_status_pkg::crs_seq_type seqState,
  input  wire logic                      commandDone,
  input  wire logic                      tallyClearCommand,
  input  wire crs_status_pkg::crs_err_type commandError,
  input  wire logic                      burstEnable,
  input  wire logic [5:0]                outputBytes,
  input  wire logic                      burstCheck,
  input  wire logic [5:0]                channelDone,
  input  wire logic                      readStrobe,
  input  wire logic [7:0]                readAddr,
  output logic      [7:0]                readData,
  output logic      [7:0]                commandResponse,
  output logic      [7:0]                channelIrqFlags
);
  import crs_status_pkg::*;

  // ==========================================================
  // state
  logic        initFinished;
  logic        errorFlag;
  logic [3:0]  lowField;
  logic [5:0]  doneFlags;
  wire  [5:0]  next_doneFlags;

  wire         overflowHit = burstCheck && burstEnable &&
                             (outputBytes > `CRS_RESULT_AREA_BYTES); // see RULE9
  wire         rejectHit   = (commandError != CRS_EV_NONE) || overflowHit; // see RULE4
  wire         acceptHit   = commandDone && !tallyClearCommand && !rejectHit;
  wire         readIrq     = readStrobe && (readAddr == `CRS_ADDR_IRQ_FLAGS);
  wire [3:0]   errCode     = overflowHit                         ? `CRS_ERR_BUF_OVERFLOW :
                             (commandError == CRS_EV_INVALID)  ? `CRS_ERR_INVALID_CMD :
                             (commandError == CRS_EV_PARAM)    ? `CRS_ERR_PARAM_RANGE :
                             (commandError == CRS_EV_SATURATE) ? `CRS_ERR_SATURATION :
                                                                 `CRS_ERR_BUF_OVERFLOW; // see RULE5
  wire         showRunning   = !initFinished || (seqState == CRS_SEQ_RUNNING); // see RULE2
  wire         showSuspended = initFinished && (seqState == CRS_SEQ_SUSPENDED);
  wire         showIdle      = !showRunning && !showSuspended;
  wire [2:0]   seqBits       = {showRunning, showSuspended, showIdle};        // see RULE1

  // ==========================================================
  // sequencer report
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      initFinished <= 1'b0;
    end else if (softRestart) begin
      initFinished <= 1'b0; // see RULE2
    end else if (initDone) begin
      initFinished <= 1'b1; // see RULE2
    end
  end

  // ==========================================================
  // error flag and tally
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      errorFlag <= 1'b0;
      lowField  <= `CRS_TALLY_RESET;
    end else if (softRestart) begin
      errorFlag <= 1'b0;             // see RULE3
      lowField  <= `CRS_TALLY_RESET; // see RULE8
    end else if (tallyClearCommand) begin
      errorFlag <= 1'b0;             // see RULE3
      lowField  <= `CRS_TALLY_ZERO;  // see RULE7 see RULE12
    end else if (rejectHit) begin
      errorFlag <= 1'b1;
      lowField  <= errCode;          // see RULE5
    end else if (acceptHit && !errorFlag) begin
      lowField  <= lowField + 4'h1;  // see RULE6
    end
  end

  // ==========================================================
  // channel done flags, set wins over read clear
  genvar ch;
  generate
    for (ch = 0; ch < `CRS_CHANNELS; ch++) begin : gDone
      assign next_doneFlags[ch] = softRestart     ? 1'b0 :
                                  channelDone[ch] ? 1'b1 : // see RULE10 see RULE13
                                  readIrq         ? 1'b0 : // see RULE10
                                                    doneFlags[ch];
      done_wins_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE10
        channelDone[ch] && !softRestart
        |=> doneFlags[ch])
        else $error("done flag lost on a read");
      done_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE13
        doneFlags[ch] && !readIrq && !softRestart
        |=> doneFlags[ch])
        else $error("done flag dropped early");
      done_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE10
        !doneFlags[ch] && !channelDone[ch]
        |=> !doneFlags[ch])
        else $error("done flag set without a result");
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      doneFlags <= 6'h00;
    end else begin
      doneFlags <= next_doneFlags;
    end
  end

  // ==========================================================
  // read port
  assign commandResponse = {seqBits, errorFlag, lowField};
  assign channelIrqFlags = {2'b00, doneFlags}; // see RULE11

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 8'h00;
    end else if (readStrobe) begin
      readData <= (readAddr == `CRS_ADDR_RESPONSE)  ? commandResponse :
                  (readAddr == `CRS_ADDR_IRQ_FLAGS) ? channelIrqFlags : 8'h00;
    end
  end

  // ==========================================================
  // checks
  tally_step_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE6
    acceptHit && !errorFlag && !softRestart |=> lowField == $past(lowField) + 4'h1)
    else $error("tally did not advance");
  tally_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE7
    tallyClearCommand && !softRestart |=> lowField == 4'h0 && !errorFlag)
    else $error("tally clear failed");
  restart_load_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE8
    softRestart |=> lowField == 4'hF && !errorFlag && commandResponse[7])
    else $error("restart load failed");
  reject_set_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE4
    rejectHit && !softRestart && !tallyClearCommand |=> errorFlag)
    else $error("error flag not set");
  overflow_code_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE9
    overflowHit && !softRestart && !tallyClearCommand |=> lowField == 4'h3)
    else $error("overflow code wrong");
  error_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
    errorFlag && !rejectHit && !softRestart && !tallyClearCommand |=> $stable(lowField))
    else $error("error code changed");
  done_set_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE10
    channelDone[0] && !softRestart |=> channelIrqFlags[0])
    else $error("done flag lost");
  read_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE10
    readIrq && channelDone == 6'h00 |=> doneFlags == 6'h00)
    else $error("read did not clear");
  top_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE11
    channelIrqFlags[7:6] == 2'b00)
    else $error("unused bits set");
  seq_onehot_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
    $onehot(commandResponse[7:5]))
    else $error("sequencer bits not one-hot");
  init_run_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE2
    !initFinished |-> commandResponse[7:5] == 3'b100)
    else $error("not running before init");

  // ==========================================================
  // sequencer bit checks
  idle_show_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE2
    initFinished && seqState == CRS_SEQ_IDLE
    |-> commandResponse[7:5] == 3'b001)
    else $error("idle not shown");

  suspend_show_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
    initFinished && seqState == CRS_SEQ_SUSPENDED
    |-> commandResponse[7:5] == 3'b010)
    else $error("suspended not shown");

  run_show_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
    initFinished && seqState == CRS_SEQ_RUNNING
    |-> commandResponse[7:5] == 3'b100)
    else $error("running not shown");

  init_take_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE2
    initDone && !softRestart
    |=> initFinished)
    else $error("init done not taken");

  restart_run_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE2
    softRestart
    |=> !initFinished && commandResponse[7:5] == 3'b100)
    else $error("restart did not show running");

  fresh_byte_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE8
    softRestart
    |=> commandResponse == 8'h8F)
    else $error("fresh restart byte wrong");

  // ==========================================================
  // error flag and code checks
  error_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE3
    softRestart || tallyClearCommand
    |=> !errorFlag)
    else $error("error flag not cleared");

  error_sticky_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE4
    errorFlag && !softRestart && !tallyClearCommand
    |=> errorFlag)
    else $error("error flag dropped");

  error_cause_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE4
    !errorFlag && commandError == CRS_EV_NONE && !overflowHit
    |=> !errorFlag)
    else $error("error flag set without cause");

  code_invalid_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
    commandError == CRS_EV_INVALID && !overflowHit && !softRestart && !tallyClearCommand
    |=> errorFlag && lowField == 4'h0)
    else $error("invalid command code wrong");

  code_param_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
    commandError == CRS_EV_PARAM && !overflowHit && !softRestart && !tallyClearCommand
    |=> errorFlag && lowField == 4'h1)
    else $error("parameter range code wrong");

  code_saturate_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
    commandError == CRS_EV_SATURATE && !overflowHit && !softRestart && !tallyClearCommand
    |=> errorFlag && lowField == 4'h2)
    else $error("saturation code wrong");

  code_overflow_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
    commandError == CRS_EV_OVERFLOW && !softRestart && !tallyClearCommand
    |=> errorFlag && lowField == 4'h3)
    else $error("buffer overflow code wrong");

  // ==========================================================
  // tally checks
  tally_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE6
    !commandDone && !rejectHit && !softRestart && !tallyClearCommand
    |=> $stable(lowField))
    else $error("tally moved without a command");

  tally_wrap_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE6
    acceptHit && !errorFlag && lowField == 4'hF && !softRestart
    |=> lowField == 4'h0)
    else $error("tally did not wrap");

  error_no_step_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE6
    acceptHit && errorFlag && !softRestart
    |=> errorFlag && $stable(lowField))
    else $error("tally advanced over an error");

  clear_init_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE12
    tallyClearCommand && !softRestart && !initDone
    |=> $stable(initFinished))
    else $error("tally clear touched init state");

  clear_flags_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE12
    tallyClearCommand && !softRestart && !readIrq && channelDone == 6'h00
    |=> $stable(doneFlags))
    else $error("tally clear touched done flags");

  // ==========================================================
  // burst overflow checks
  burst_off_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE9
    burstCheck && !burstEnable && commandError == CRS_EV_NONE && !errorFlag && !softRestart
    |=> !errorFlag)
    else $error("overflow raised without burst");

  burst_fit_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE9
    burstCheck && outputBytes <= 6'h1A && commandError == CRS_EV_NONE && !errorFlag
    && !softRestart |=> !errorFlag)
    else $error("overflow raised for a fitting output");

  // ==========================================================
  // read port checks
  read_resp_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
    readStrobe && readAddr == `CRS_ADDR_RESPONSE
    |=> readData == $past(commandResponse))
    else $error("response read wrong");

  read_flags_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE10
    readStrobe && readAddr == `CRS_ADDR_IRQ_FLAGS
    |=> readData == $past(channelIrqFlags))
    else $error("done flags read wrong");

  read_top_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE11
    readStrobe && readAddr == `CRS_ADDR_IRQ_FLAGS
    |=> readData[7:6] == 2'b00)
    else $error("unused flag bits read set");

  restart_flags_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE10
    softRestart
    |=> doneFlags == 6'h00)
    else $error("restart left done flags");
endmodule : crs_status

/* File: test/crs_host_model.sv */
// host model that reads the status registers
`timescale 1ns/1ps
module crs_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] readData,
  output logic            readStrobe,
  output logic      [7:0] readAddr
);
  initial begin
    readStrobe = 1'b0;
    readAddr   = 8'h00;
  end
  // read back one register at the given address
  task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    readStrobe = 1'b1;
    readAddr   = addr;
    @(negedge clock);
    data       = readData;
    readStrobe = 1'b0;
    readAddr   = ~addr;
  endtask : readReg
endmodule : crs_host_model

/* File: test/tb_crs_status.sv */
// testbench of the command response and channel status registers
`timescale 1ns/1ps
module tb_crs_status;
  import crs_status_pkg::*;
  logic        clock, rst_n, softRestart, initDone, commandDone, tallyClearCommand;
  logic        burstEnable, burstCheck, readStrobe;
  crs_seq_type seqState;
  crs_err_type commandError;
  logic [5:0]  outputBytes, channelDone;
  logic [7:0]  readAddr, readData, commandResponse, channelIrqFlags, seen;
  int          numErrors, checkCount, cycles;
  crs_status crs_status_i (.clock(clock), .rst_n(rst_n), .softRestart(softRestart),
    .initDone(initDone), .seqState(seqState), .commandDone(commandDone),
    .tallyClearCommand(tallyClearCommand), .commandError(commandError),
    .burstEnable(burstEnable), .outputBytes(outputBytes), .burstCheck(burstCheck),
    .channelDone(channelDone), .readStrobe(readStrobe), .readAddr(readAddr),
    .readData(readData), .commandResponse(commandResponse),
    .channelIrqFlags(channelIrqFlags));
  crs_host_model crs_host_model_i (.clock(clock), .readData(readData),
    .readStrobe(readStrobe), .readAddr(readAddr));
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      giveVerdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic giveVerdict();
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : giveVerdict
  task automatic step();
    @(negedge clock);
  endtask : step
  task automatic startup();
    crs_seq_type st[3] = '{CRS_SEQ_SUSPENDED, CRS_SEQ_RUNNING, CRS_SEQ_IDLE};
    logic [7:0]  ex[3] = '{8'h4F, 8'h8F, 8'h2F};
    check(commandResponse, 8'h8F);
    check(channelIrqFlags, 8'h00);
    crs_host_model_i.readReg(8'h11, seen);
    check(seen, 8'h8F);
    initDone = 1'b1;
    foreach (st[i]) begin
      seqState = st[i];
      step();
      check(commandResponse, ex[i]);
    end
  endtask : startup
  task automatic tally();
    commandDone = 1'b1;
    step();
    check(commandResponse, 8'h20);
    step();
    check(commandResponse, 8'h21);
    tallyClearCommand = 1'b1;
    step();
    commandDone = 1'b0;
    tallyClearCommand = 1'b0;
    check(commandResponse, 8'h20);
  endtask : tally
  task automatic errors();
    for (int e = 1; e <= 4; e++) begin
      commandError = crs_err_type'(e);
      commandDone = 1'b1;
      step();
      commandError = CRS_EV_NONE;
      step();
      commandDone = 1'b0;
      check(commandResponse, 8'h30 + 8'(e - 1));
      tallyClearCommand = 1'b1;
      step();
      tallyClearCommand = 1'b0;
      check(commandResponse, 8'h20);
    end
  endtask : errors
  task automatic burst();
    outputBytes = 6'h1B;
    burstCheck = 1'b1;
    step();
    check(commandResponse, 8'h20);
    burstEnable = 1'b1;
    outputBytes = 6'h1A;
    step();
    check(commandResponse, 8'h20);
    outputBytes = 6'h1B;
    step();
    burstCheck = 1'b0;
    check(commandResponse, 8'h33);
  endtask : burst
  task automatic flags();
    channelDone = 6'h21;
    step();
    channelDone = 6'h14;
    step();
    channelDone = 6'h00;
    check(channelIrqFlags, 8'h35);
    crs_host_model_i.readReg(8'h12, seen);
    check(seen, 8'h35);
    check(channelIrqFlags, 8'h00);
    crs_host_model_i.readReg(8'h13, seen);
    check(seen, 8'h00);
    channelDone = 6'h01;
    step();
    channelDone = 6'h00;
    fork
      crs_host_model_i.readReg(8'h12, seen);
      begin
        step();
        channelDone = 6'h02;
        step();
        channelDone = 6'h00;
      end
    join
    check(seen, 8'h01);
    check(channelIrqFlags, 8'h02);
  endtask : flags
  task automatic restart();
    channelDone = 6'h08;
    step();
    channelDone = 6'h00;
    softRestart = 1'b1;
    step();
    softRestart = 1'b0;
    check(commandResponse, 8'h8F);
    check(channelIrqFlags, 8'h00);
  endtask : restart
  initial begin
    {clock, rst_n, softRestart, initDone, commandDone, tallyClearCommand} = '0;
    {burstEnable, burstCheck, outputBytes, channelDone} = '0;
    seqState = CRS_SEQ_RUNNING;
    commandError = CRS_EV_NONE;
    repeat (20) step();
    rst_n = 1'b1;
    startup();
    tally();
    errors();
    burst();
    restart();
    flags();
    giveVerdict();
  end
endmodule : tb_crs_status
